/* File: hdl/eipf_pkg.sv */
// Package for the external and peripheral interrupt flag block: map, fields, resets, carriers
package eipf_pkg;

	// ************************************************************
	// Register map (byte addresses)
	// ************************************************************
	localparam logic [7:0] EIPF_OFF_EDGE_PRIO = 8'h00;
	localparam logic [7:0] EIPF_OFF_EXT_CTRL = 8'h04;
	localparam logic [7:0] EIPF_OFF_FLAGS_ONE = 8'h08;
	localparam logic [7:0] EIPF_OFF_FLAGS_TWO = 8'h0c;
	localparam logic [7:0] EIPF_OFF_GATE = 8'h10;
	localparam logic [7:0] EIPF_OFF_PERIPH_EN = 8'h14;
	localparam logic [7:0] EIPF_OFF_PERIPH_PRIO = 8'h18;

	// ************************************************************
	// Reset values
	// ************************************************************
	localparam logic [7:0] EIPF_RST_EDGE_PRIO = 8'hff;
	localparam logic [7:0] EIPF_RST_EXT_CTRL = 8'hc0;
	localparam logic [7:0] EIPF_RST_FLAGS = 8'h00;
	localparam logic [7:0] EIPF_RST_GATE = 8'h00;
	localparam logic [15:0] EIPF_RST_PERIPH_EN = 16'h0000;
	localparam logic [15:0] EIPF_RST_PERIPH_PRIO = 16'hffff;

	// ************************************************************
	// Field positions
	// ************************************************************
	localparam int EIPF_B_PULLUP_DIS = 7;
	localparam int EIPF_B_EDGE_SEL0 = 6;
	localparam int EIPF_B_TMR0_PRIO = 2;
	localparam int EIPF_B_EXT3_PRIO = 1;
	localparam int EIPF_B_PORT_PRIO = 0;
	localparam int EIPF_B_EXT2_PRIO = 7;
	localparam int EIPF_B_EXT1_PRIO = 6;
	localparam int EIPF_B_EXT1_EN = 3;
	localparam int EIPF_B_EXT1_FLAG = 0;
	localparam int EIPF_B_CONV_DONE = 6;
	localparam int EIPF_B_RX_FULL = 5;
	localparam int EIPF_B_TX_EMPTY = 4;
	localparam int EIPF_B_CMP0 = 1;
	localparam int EIPF_B_TMR1 = 0;
	localparam int EIPF_B_OSC_FAIL = 7;
	localparam int EIPF_B_NV_DONE = 4;
	localparam int EIPF_B_LOW_VOLT = 2;
	localparam int EIPF_B_GLOBAL_HIGH = 7;
	localparam int EIPF_B_PERIPH_LOW = 6;
	localparam int EIPF_B_PRIO_MODE = 5;
	// Implemented bits of the flag and gate registers; all others read as zero
	localparam logic [7:0] EIPF_MASK_FLAGS_ONE = 8'h7f;
	localparam logic [7:0] EIPF_MASK_FLAGS_TWO = 8'h94;
	localparam logic [7:0] EIPF_MASK_GATE = 8'he0;

	// ************************************************************
	// Vectors and bus answers
	// ************************************************************
	localparam logic [15:0] EIPF_VEC_HIGH = 16'h0008;
	localparam logic [15:0] EIPF_VEC_LOW = 16'h0018;
	localparam logic [1:0] EIPF_RESP_OKAY = 2'h0;
	localparam logic [1:0] EIPF_RESP_SLVERR = 2'h2;

	// ************************************************************
	// Carriers
	// ************************************************************
	typedef struct packed {
		logic awvalid;
		logic [7:0] awaddr;
		logic wvalid;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bready;
		logic arvalid;
		logic [7:0] araddr;
		logic rready;
	} eipf_axi_req_t;

	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} eipf_axi_rsp_t;

	typedef struct packed {
		logic conv_done;
		logic serial_rx_full;
		logic serial_tx_empty;
		logic timer1_ovf;
		logic osc_fail;
		logic nv_write_done;
		logic low_voltage;
		logic timer0_req;
		logic port_change_req;
		logic ext0_req;
	} eipf_events_t;

	typedef struct packed {
		logic [7:0] edge_prio;
		logic [7:0] ext_ctrl;
		logic [7:0] flags_one;
		logic [7:0] flags_two;
		logic [7:0] gate;
		logic [15:0] periph_en;
		logic [15:0] periph_prio;
		logic [3:0] ext_s1;
		logic [3:0] ext_s2;
		logic [3:0] ext_s3;
		logic [2:0] cmp_s1;
		logic [2:0] cmp_s2;
		logic [2:0] cmp_s3;
		logic aw_have;
		logic [7:0] aw_addr;
		logic w_have;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		eipf_axi_rsp_t axi;
		logic [7:0] pullup_en;
		logic ext0_edge;
		logic irq_high;
		logic irq_any;
		logic [15:0] vector;
	} eipf_state_t;

endpackage : eipf_pkg

/* File: hdl/eipf_top.sv */
// External pin and peripheral interrupt flags with AXI4-Lite register access
`timescale 1ns/1ps

// How it works
// - Pull-up disable bit forces all port pull-ups off
// - Per-pin edge select: 1 rising, 0 falling
// - Priority bit 1 high, 0 low per source
// - External 1-3 enables gate their requests
// - External 1-3 flags set on edge, software clears
// - Flags set regardless of any enable bit
// - Conversion-done flag set, held until software clears
// - Receive flag read-only, mirrors buffer holding data
// - Transmit flag read-only, mirrors buffer being empty
// - Timer 1 overflow flag, cleared only by software
// - Oscillator-fail flag set on clock failure, software clears
// - Nonvolatile write-done flag, software clears
// - Low-voltage flag set on detection
// - Unimplemented flag bits always read zero
// - Three comparator flags, readable and writable
// - Compatibility mode ignores priority, single vector
// - Priority mode vectors high 0008h, low 0018h
// - Compatibility: peripheral enable gates peripherals, global gates all
module eipf_top
	import eipf_pkg::*;
(
	input wire logic clock_i,
	input wire logic rst_b_i,
	input wire eipf_axi_req_t axi_req_i,
	output eipf_axi_rsp_t axi_rsp_o,
	input wire logic [3:0] ext_pin_i,
	input wire logic [2:0] cmp_out_i,
	input wire eipf_events_t events_i,
	input wire logic [7:0] port_latch_i,
	output logic [7:0] pullup_en_o,
	output logic ext0_edge_o,
	output logic irq_o,
	output logic irq_high_o,
	output logic [15:0] irq_vector_o
);

	eipf_state_t s_q;
	eipf_state_t s_d;

	// ************************************************************
	// Next state
	// ************************************************************
	always_comb begin
		logic [3:0] ext_edge;
		logic [2:0] cmp_chg;
		logic do_wr;
		logic wr_hit;
		logic rd_hit;
		logic [31:0] rd_val;
		logic [7:0] src_hi;
		logic [7:0] src_lo;
		logic [15:0] per_req;
		logic core_any;
		logic per_any;
		logic hi_any;
		logic lo_any;
		logic gie;
		logic peie;
		logic compat;
		s_d = s_q;
		ext_edge = '0;
		cmp_chg = '0;
		rd_val = '0;
		rd_hit = 1'b1;
		wr_hit = 1'b1;
		src_hi = '0;
		src_lo = '0;
		do_wr = 1'b0;
		per_req = '0;
		core_any = 1'b0;
		per_any = 1'b0;
		hi_any = 1'b0;
		lo_any = 1'b0;
		gie = 1'b0;
		peie = 1'b0;
		compat = 1'b1;


		// Pins cross in through two flops; the third holds the old level
		// A pin already high at reset release reads as one rising edge
		s_d.ext_s1 = ext_pin_i;
		s_d.ext_s2 = s_q.ext_s1;
		s_d.ext_s3 = s_q.ext_s2;
		s_d.cmp_s1 = cmp_out_i;
		s_d.cmp_s2 = s_q.cmp_s1;
		s_d.cmp_s3 = s_q.cmp_s2;
		for (int i = 0; i < 4; i++) begin
			if (s_q.edge_prio[EIPF_B_EDGE_SEL0 - i]) begin
				ext_edge[i] = s_q.ext_s2[i] & ~s_q.ext_s3[i];
			end else begin
				ext_edge[i] = ~s_q.ext_s2[i] & s_q.ext_s3[i];
			end
		end
		// Comparator flags take a change in either direction
		for (int i = 0; i < 3; i++) begin
			cmp_chg[i] = s_q.cmp_s2[i] ^ s_q.cmp_s3[i];
		end

		// AXI4-Lite write: address and data taken in either order
		if (s_q.axi.awready && axi_req_i.awvalid) begin
			s_d.aw_have = 1'b1;
			s_d.aw_addr = axi_req_i.awaddr;
		end
		if (s_q.axi.wready && axi_req_i.wvalid) begin
			s_d.w_have = 1'b1;
			s_d.w_data = axi_req_i.wdata;
			s_d.w_strb = axi_req_i.wstrb;
		end
		// The write lands one edge after both halves are held
		do_wr = s_q.aw_have && s_q.w_have && !s_q.axi.bvalid;
		if (do_wr) begin
			unique case (s_q.aw_addr)
				EIPF_OFF_EDGE_PRIO: begin
					if (s_q.w_strb[0]) begin
						s_d.edge_prio = s_q.w_data[7:0];
					end
				end
				EIPF_OFF_EXT_CTRL: begin
					if (s_q.w_strb[0]) begin
						s_d.ext_ctrl = s_q.w_data[7:0];
					end
				end
				EIPF_OFF_FLAGS_ONE: begin
					// Receive and transmit bits are not writable
					if (s_q.w_strb[0]) begin
						s_d.flags_one[EIPF_B_CONV_DONE] = s_q.w_data[EIPF_B_CONV_DONE];
						s_d.flags_one[3:0] = s_q.w_data[3:0];
					end
				end
				EIPF_OFF_FLAGS_TWO: begin
					if (s_q.w_strb[0]) begin
						s_d.flags_two = s_q.w_data[7:0] & EIPF_MASK_FLAGS_TWO;
					end
				end
				EIPF_OFF_GATE: begin
					if (s_q.w_strb[0]) begin
						s_d.gate = s_q.w_data[7:0] & EIPF_MASK_GATE;
					end
				end
				EIPF_OFF_PERIPH_EN: begin
					if (s_q.w_strb[0]) begin
						s_d.periph_en[7:0] = s_q.w_data[7:0];
					end
					if (s_q.w_strb[1]) begin
						s_d.periph_en[15:8] = s_q.w_data[15:8];
					end
				end
				EIPF_OFF_PERIPH_PRIO: begin
					if (s_q.w_strb[0]) begin
						s_d.periph_prio[7:0] = s_q.w_data[7:0];
					end
					if (s_q.w_strb[1]) begin
						s_d.periph_prio[15:8] = s_q.w_data[15:8];
					end
				end
				default: wr_hit = 1'b0;
			endcase
			s_d.aw_have = 1'b0;
			s_d.w_have = 1'b0;
			s_d.axi.bvalid = 1'b1;
			// Unmapped writes change nothing and answer with an error
			if (wr_hit) begin
				s_d.axi.bresp = EIPF_RESP_OKAY;
			end else begin
				s_d.axi.bresp = EIPF_RESP_SLVERR;
			end
		end
		if (s_q.axi.bvalid && axi_req_i.bready) begin
			s_d.axi.bvalid = 1'b0;
		end
		// Each ready drops while its own half is held or the answer waits: one write at a time
		s_d.axi.awready = !s_d.aw_have && !s_d.axi.bvalid;
		s_d.axi.wready = !s_d.w_have && !s_d.axi.bvalid;

		// Hardware events OR in after the software write, so a set wins
		for (int i = 0; i < 3; i++) begin
			s_d.ext_ctrl[EIPF_B_EXT1_FLAG + i] = s_d.ext_ctrl[EIPF_B_EXT1_FLAG + i]
				| ext_edge[i + 1];
			s_d.flags_one[EIPF_B_CMP0 + i] = s_d.flags_one[EIPF_B_CMP0 + i]
				| cmp_chg[i];
		end
		s_d.flags_one[EIPF_B_CONV_DONE] = s_d.flags_one[EIPF_B_CONV_DONE]
			| events_i.conv_done;
		s_d.flags_one[EIPF_B_TMR1] = s_d.flags_one[EIPF_B_TMR1] | events_i.timer1_ovf;
		// Buffer state is owned by the serial unit; it drops these on read or write
		s_d.flags_one[EIPF_B_RX_FULL] = events_i.serial_rx_full;
		s_d.flags_one[EIPF_B_TX_EMPTY] = events_i.serial_tx_empty;
		// Masks keep unused bits at zero whatever is written
		s_d.flags_one = s_d.flags_one & EIPF_MASK_FLAGS_ONE;
		s_d.flags_two[EIPF_B_OSC_FAIL] = s_d.flags_two[EIPF_B_OSC_FAIL]
			| events_i.osc_fail;
		s_d.flags_two[EIPF_B_NV_DONE] = s_d.flags_two[EIPF_B_NV_DONE]
			| events_i.nv_write_done;
		s_d.flags_two[EIPF_B_LOW_VOLT] = s_d.flags_two[EIPF_B_LOW_VOLT]
			| events_i.low_voltage;
		s_d.flags_two = s_d.flags_two & EIPF_MASK_FLAGS_TWO;

		// AXI4-Lite read
		// Data come from the registers at the address edge; a set in that cycle shows next read
		if (s_q.axi.arready && axi_req_i.arvalid) begin
			unique case (axi_req_i.araddr)
				EIPF_OFF_EDGE_PRIO: begin
					rd_val = {24'h000000, s_q.edge_prio};
				end
				EIPF_OFF_EXT_CTRL: begin
					rd_val = {24'h000000, s_q.ext_ctrl};
				end
				EIPF_OFF_FLAGS_ONE: begin
					rd_val = {24'h000000, s_q.flags_one};
				end
				EIPF_OFF_FLAGS_TWO: begin
					rd_val = {24'h000000, s_q.flags_two};
				end
				EIPF_OFF_GATE: begin
					rd_val = {24'h000000, s_q.gate};
				end
				EIPF_OFF_PERIPH_EN: begin
					rd_val = {16'h0000, s_q.periph_en};
				end
				EIPF_OFF_PERIPH_PRIO: begin
					rd_val = {16'h0000, s_q.periph_prio};
				end
				default: rd_hit = 1'b0;
			endcase
			s_d.axi.rvalid = 1'b1;
			s_d.axi.rdata = rd_val;
			if (rd_hit) begin
				s_d.axi.rresp = EIPF_RESP_OKAY;
			end else begin
				s_d.axi.rresp = EIPF_RESP_SLVERR;
			end
		end else if (s_q.axi.rvalid && axi_req_i.rready) begin
			s_d.axi.rvalid = 1'b0;
		end
		s_d.axi.arready = !s_d.axi.rvalid;

		// Pull-ups
		// They follow the latch one clock late, so the pins see no gate glitch
		if (s_q.edge_prio[EIPF_B_PULLUP_DIS]) begin
			s_d.pullup_en = 8'h00;
		end else begin
			s_d.pullup_en = port_latch_i;
		end
		s_d.ext0_edge = ext_edge[0];

		// Request and vector
		gie = s_q.gate[EIPF_B_GLOBAL_HIGH];
		peie = s_q.gate[EIPF_B_PERIPH_LOW];
		compat = !s_q.gate[EIPF_B_PRIO_MODE];
		// Serial flags mirror the buffers, so they request for as long as enabled
		per_req = {s_q.flags_two, s_q.flags_one} & s_q.periph_en;
		// Sources: 0 ext0, 1 timer0, 2 port change, 3..5 ext1..3
		// Input 0 has no priority bit and is always high
		src_hi[0] = events_i.ext0_req;
		if (s_q.edge_prio[EIPF_B_TMR0_PRIO]) begin
			src_hi[1] = events_i.timer0_req;
		end else begin
			src_lo[1] = events_i.timer0_req;
		end
		if (s_q.edge_prio[EIPF_B_PORT_PRIO]) begin
			src_hi[2] = events_i.port_change_req;
		end else begin
			src_lo[2] = events_i.port_change_req;
		end
		// External 1 to 3 request only when flag and enable are both set
		for (int i = 0; i < 3; i++) begin
			logic req;
			logic hi;
			req = s_q.ext_ctrl[EIPF_B_EXT1_FLAG + i] & s_q.ext_ctrl[EIPF_B_EXT1_EN + i];
			unique case (i)
				0: begin
					hi = s_q.ext_ctrl[EIPF_B_EXT1_PRIO];
				end
				1: begin
					hi = s_q.ext_ctrl[EIPF_B_EXT2_PRIO];
				end
				default: begin
					hi = s_q.edge_prio[EIPF_B_EXT3_PRIO];
				end
			endcase
			src_hi[3 + i] = req & hi;
			src_lo[3 + i] = req & ~hi;
		end
		core_any = |(src_hi | src_lo);
		per_any = |per_req;
		// Peripheral priority uses the same bit layout as the enables
		hi_any = (|src_hi) | (|(per_req & s_q.periph_prio));
		lo_any = (|src_lo) | (|(per_req & ~s_q.periph_prio));

		if (compat) begin
			// One vector and no low level; priority bits are ignored here
			s_d.irq_high = gie & (core_any | (peie & per_any));
			s_d.irq_any = s_d.irq_high;
			s_d.vector = EIPF_VEC_HIGH;
		end else begin
			s_d.irq_high = gie & hi_any;
			s_d.irq_any = gie & (hi_any | (peie & lo_any));
			if (gie & hi_any) begin
				s_d.vector = EIPF_VEC_HIGH;
			end else begin
				s_d.vector = EIPF_VEC_LOW;
			end
		end
	end

	// ************************************************************
	// State register
	// ************************************************************
	always_ff @(posedge clock_i) begin
		if (!rst_b_i) begin
			s_q <= '0;
			// Nonzero resets are loaded over the blanket clear
			s_q.edge_prio <= EIPF_RST_EDGE_PRIO;
			s_q.ext_ctrl <= EIPF_RST_EXT_CTRL;
			s_q.flags_one <= EIPF_RST_FLAGS;
			s_q.flags_two <= EIPF_RST_FLAGS;
			s_q.gate <= EIPF_RST_GATE;
			s_q.periph_en <= EIPF_RST_PERIPH_EN;
			s_q.periph_prio <= EIPF_RST_PERIPH_PRIO;
			s_q.vector <= EIPF_VEC_HIGH;
		end else begin
			s_q <= s_d;
		end
	end

	// ************************************************************
	// Outputs
	// ************************************************************
	assign axi_rsp_o = s_q.axi;
	assign pullup_en_o = s_q.pullup_en;
	assign ext0_edge_o = s_q.ext0_edge;
	// The any-request level has a flop of its own, so the core never sees a gate glitch
	assign irq_o = s_q.irq_any;
	assign irq_high_o = s_q.irq_high;
	assign irq_vector_o = s_q.vector;

endmodule : eipf_top

/* File: tb/eipf_checker.sv */
// Concurrent checks on the ports of the interrupt flag block
`timescale 1ns/1ps
module eipf_checker
	import eipf_pkg::*;
(
	input wire logic clock_i,
	input wire logic rst_b_i,
	input wire eipf_axi_req_t axi_req_i,
	input wire eipf_axi_rsp_t axi_rsp_o,
	input wire logic [3:0] ext_pin_i,
	input wire logic [2:0] cmp_out_i,
	input wire eipf_events_t events_i,
	input wire logic [7:0] port_latch_i,
	input wire logic [7:0] pullup_en_o,
	input wire logic ext0_edge_o,
	input wire logic irq_o,
	input wire logic irq_high_o,
	input wire logic [15:0] irq_vector_o
);
	// ********
	// Helpers
	// ********
	logic [7:0] ar_q;
	logic [31:0] used_m;
	always_ff @(posedge clock_i) begin
		if (axi_req_i.arvalid && axi_rsp_o.arready) begin
			ar_q <= axi_req_i.araddr;
		end
	end
	// Only flag reads are masked; other registers have their own widths
	assign used_m = {24'h0, (ar_q == EIPF_OFF_FLAGS_ONE) ? EIPF_MASK_FLAGS_ONE : EIPF_MASK_FLAGS_TWO};
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!rst_b_i);
	sequence wr_taken;
		axi_req_i.awvalid && axi_rsp_o.awready && axi_req_i.wvalid && axi_rsp_o.wready;
	endsequence
	sequence rd_taken;
		axi_req_i.arvalid && axi_rsp_o.arready;
	endsequence
	// ********
	// Assertions
	// ********
	pullup_a: assert property (pullup_en_o == 8'h00 || pullup_en_o == $past(port_latch_i))
		else $error("pull-up enables neither off nor latch");
	edge_src_a: assert property (ext0_edge_o |-> $past(ext_pin_i[0], 3) != $past(ext_pin_i[0], 4)
		|| $past(ext_pin_i[0], 4) != $past(ext_pin_i[0], 5)) else $error("edge pulse without pin change");
	edge_once_a: assert property (ext0_edge_o |=> !ext0_edge_o)
		else $error("edge pulse longer than one cycle");
	reset_idle_a: assert property (disable iff (1'b0) !rst_b_i |=> !irq_o
		&& pullup_en_o == 8'h00 && irq_vector_o == EIPF_VEC_HIGH) else $error("outputs not idle in reset");
	high_vec_a: assert property (irq_high_o |-> irq_vector_o == EIPF_VEC_HIGH)
		else $error("high request with wrong vector");
	low_vec_a: assert property (irq_o && !irq_high_o |-> irq_vector_o == EIPF_VEC_LOW)
		else $error("low request with wrong vector");
	high_req_a: assert property (irq_high_o |-> irq_o)
		else $error("high request without request");
	unimpl_zero_a: assert property (axi_rsp_o.rvalid && (ar_q == EIPF_OFF_FLAGS_ONE
		|| ar_q == EIPF_OFF_FLAGS_TWO) |-> (axi_rsp_o.rdata & ~used_m) == 32'h0)
		else $error("unimplemented flag bit read as one");
	write_ans_a: assert property (wr_taken |-> ##2 axi_rsp_o.bvalid)
		else $error("write answer late");
	read_ans_a: assert property (rd_taken |=> axi_rsp_o.rvalid)
		else $error("read answer late");
endmodule : eipf_checker

bind eipf_top eipf_checker u_eipf_checker (.clock_i(clock_i), .rst_b_i(rst_b_i),
	.axi_req_i(axi_req_i), .axi_rsp_o(axi_rsp_o), .ext_pin_i(ext_pin_i), .cmp_out_i(cmp_out_i),
	.events_i(events_i), .port_latch_i(port_latch_i), .pullup_en_o(pullup_en_o),
	.ext0_edge_o(ext0_edge_o), .irq_o(irq_o), .irq_high_o(irq_high_o), .irq_vector_o(irq_vector_o));

/* File: tb/eipf_src.sv */
// Model of the peripheral event sources and serial buffers
`timescale 1ns/1ps
module eipf_src
	import eipf_pkg::*;
(
	input wire logic clock_i,
	input wire logic rst_b_i,
	input wire logic fire_i,
	input wire logic [3:0] sel_i,
	input wire logic rx_rd_i,
	input wire logic tx_wr_i,
	output eipf_events_t events_o
);
	logic [9:0] ev_q;
	logic rx_q;
	logic tx_q;
	always_ff @(posedge clock_i) begin
		ev_q <= '0;
		if (!rst_b_i) begin
			rx_q <= 1'b0;
			tx_q <= 1'b1;
		end else begin
			// One event pulse for each cycle that fire is held
			ev_q[sel_i] <= fire_i;
			rx_q <= (rx_q || (fire_i && sel_i == 4'h8)) && !rx_rd_i;
			tx_q <= (tx_q || (fire_i && sel_i == 4'h7)) && !tx_wr_i;
		end
	end
	assign events_o = ev_q | {1'b0, rx_q, tx_q, 7'h00};
endmodule : eipf_src

/* File: tb/eipf_top_tb.sv */
// Self-checking bench for the interrupt flag block
`timescale 1ns/1ps
module eipf_top_tb
	import eipf_pkg::*;
;
	logic clock_i, rst_b_i, ext0_edge_o, irq_o, irq_high_o, fire_q, rx_rd, tx_wr;
	eipf_axi_req_t req;
	eipf_axi_rsp_t rsp;
	eipf_events_t ev;
	logic [3:0] ext_pin_i, sel;
	logic [2:0] cmp_out_i;
	logic [7:0] port_latch_i, pullup_en_o;
	logic [15:0] irq_vector_o;
	logic [31:0] rd_d;
	logic [1:0] rd_r, b_r;
	int n_errors, samples_checked, cyc, seed, rx, tx, n_e0;
	int m[7];
	int wm[7] = '{'hff, 'hff, 'h4f, 'h94, 'he0, 'hffff, 'hffff};
	int er[5] = '{2, 2, 3, 3, 3};
	int eb[5] = '{6, 0, 7, 4, 2};
	int es[5] = '{9, 6, 5, 4, 3};
	eipf_top u_eipf_top (.clock_i(clock_i), .rst_b_i(rst_b_i), .axi_req_i(req), .axi_rsp_o(rsp),
		.ext_pin_i(ext_pin_i), .cmp_out_i(cmp_out_i), .events_i(ev), .port_latch_i(port_latch_i),
		.pullup_en_o(pullup_en_o), .ext0_edge_o(ext0_edge_o), .irq_o(irq_o),
		.irq_high_o(irq_high_o), .irq_vector_o(irq_vector_o));
	eipf_src u_eipf_src (.clock_i(clock_i), .rst_b_i(rst_b_i), .fire_i(fire_q), .sel_i(sel),
		.rx_rd_i(rx_rd), .tx_wr_i(tx_wr), .events_o(ev));
	// ********
	// Tasks
	// ********
	task automatic tally_and_finish();
		if (n_errors == 0 && samples_checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : tally_and_finish
	task automatic cmp(input string s, input logic [31:0] g, input logic [31:0] e);
		samples_checked++;
		if (g !== e) begin
			n_errors++;
			$display("Error %s expected %h seen %h", s, e, g);
		end
	endtask : cmp
	task automatic wait_c(input int n);
		repeat (n) @(posedge clock_i);
	endtask : wait_c
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clock_i);
		req <= '{awvalid: 1'b1, awaddr: a, wvalid: 1'b1, wdata: d, wstrb: 4'hf, bready: 1'b1,
			default: '0};
		// Each channel is released at the edge that takes it
		do begin
			@(posedge clock_i);
			if (rsp.awready) req.awvalid <= 1'b0;
			if (rsp.wready) req.wvalid <= 1'b0;
		end while (!rsp.bvalid);
		b_r = rsp.bresp;
		req.bready <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a);
		@(posedge clock_i);
		req <= '{arvalid: 1'b1, araddr: a, rready: 1'b1, default: '0};
		do begin
			@(posedge clock_i);
			if (rsp.arready) req.arvalid <= 1'b0;
		end while (!rsp.rvalid);
		rd_d = rsp.rdata;
		rd_r = rsp.rresp;
		req.rready <= 1'b0;
	endtask : rd
	function automatic int ex(input int i);
		return (i == 2) ? ((m[2] & 'h4f) | (rx << 5) | (tx << 4)) : m[i];
	endfunction : ex
	task automatic put(input int i, input int v);
		wr(8'(i * 4), 32'(v));
		m[i] = v & wm[i];
	endtask : put
	task automatic rchk(input int i);
		rd(8'(i * 4));
		cmp("rresp", 32'(rd_r), 32'(EIPF_RESP_OKAY));
		cmp("rdata", rd_d, 32'(ex(i)));
	endtask : rchk
	task automatic fire(input int k);
		sel <= 4'(k);
		fire_q <= 1'b1;
		@(posedge clock_i);
		fire_q <= 1'b0;
		wait_c(4);
	endtask : fire
	task automatic irq_chk(input int i, input int h, input int v);
		wait_c(3);
		cmp("irq", 32'(irq_o), 32'(i));
		cmp("irq_high", 32'(irq_high_o), 32'(h));
		cmp("vector", 32'(irq_vector_o), 32'(v));
	endtask : irq_chk
	// ********
	// Sequence
	// ********
	initial begin
		clock_i = 1'b0;
		forever #50 clock_i = ~clock_i;
	end
	// Ceiling well above the few hundred cycles the sequence needs
	always @(posedge clock_i) begin
		cyc++;
		if (ext0_edge_o === 1'b1) n_e0++;
		if (cyc == 20000) begin
			n_errors++;
			tally_and_finish();
		end
	end
	initial begin
		seed = 35;
		{rst_b_i, fire_q, rx_rd, tx_wr, ext_pin_i, cmp_out_i, sel, port_latch_i} = '0;
		req = '0;
		m = '{'hff, 'hc0, 0, 0, 0, 0, 'hffff};
		rx = 0;
		tx = 1;
		repeat (12) @(posedge clock_i);
		rst_b_i <= 1'b1;
		for (int i = 0; i < 7; i++) rchk(i);
		rd(8'h1c);
		cmp("rresp", 32'(rd_r), 32'(EIPF_RESP_SLVERR));
		cmp("rdata", rd_d, 32'h0);
		wr(8'h1c, 32'hffffffff);
		cmp("bresp", 32'(b_r), 32'(EIPF_RESP_SLVERR));
		put(0, $random(seed) & 'h7f);
		rchk(0);
		port_latch_i <= 8'($random(seed));
		wait_c(4);
		cmp("pullup", 32'(pullup_en_o), 32'(port_latch_i));
		put(0, 'hff);
		wait_c(2);
		cmp("pullup", 32'(pullup_en_o), 32'h0);
		for (int p = 1; p >= 0; p--) begin
			put(0, p ? 'hff : 'h87);
			for (int s = 0; s < 2; s++) begin
				put(1, p ? 'hc0 : 'hf8);
				ext_pin_i <= ~ext_pin_i;
				wait_c(5);
				if (ext_pin_i[1] == p[0]) m[1] |= 7;
				rchk(1);
			end
		end
		cmp("ext0_edge", 32'(n_e0), 32'h2);
		put(1, 'hc0);
		for (int j = 0; j < 3; j++) begin
			cmp_out_i[j] <= 1'b1;
			wait_c(5);
			m[2] |= 2 << j;
			rchk(2);
		end
		put(2, 'h0a);
		rchk(2);
		for (int i = 0; i < 5; i++) begin
			put(er[i], 0);
			fire(es[i]);
			m[er[i]] |= 1 << eb[i];
			wait_c(8);
			rchk(er[i]);
		end
		put(3, 0);
		rchk(3);
		fire(8);
		rx = 1;
		put(2, 0);
		rchk(2);
		rx_rd <= 1'b1;
		tx_wr <= 1'b1;
		@(posedge clock_i);
		rx_rd <= 1'b0;
		tx_wr <= 1'b0;
		{rx, tx} = '0;
		rchk(2);
		fire(7);
		tx = 1;
		rchk(2);
		put(5, 1);
		put(4, 'hc0);
		fire(6);
		m[2] |= 1;
		irq_chk(1, 1, 'h0008);
		put(4, 'h80);
		irq_chk(0, 0, 'h0008);
		put(6, 'hfffe);
		put(4, 'hc0);
		irq_chk(1, 1, 'h0008);
		put(4, 'he0);
		irq_chk(1, 0, 'h0018);
		put(4, 'ha0);
		irq_chk(0, 0, 'h0018);
		put(6, 'hffff);
		irq_chk(1, 1, 'h0008);
		put(2, 0);
		irq_chk(0, 0, 'h0018);
		put(5, 0);
		fire(6);
		irq_chk(0, 0, 'h0018);
		tally_and_finish();
	end
endmodule : eipf_top_tb
